// ---- rtl/flag_bus_pkg.sv ----
// Constants shared by both ends of the queue flag status link.
// Assumes one system clock stands in for both the read and the write clock.
package flag_bus_pkg;
    localparam int          FLAG_W        = 8;     // Flags shown per quadrant.
    localparam int          QUAD_W        = 2;     // Quadrant index width.
    localparam int          QUEUE_W       = 5;     // Queue index within one device.
    localparam int          QUEUES        = 32;    // Queues owned by one device.
    localparam int          ADDR_W        = 8;     // Queue address bus width.
    localparam int          ID_W          = 3;     // Device identity width.
    localparam int          ADDR_ID_LSB   = 5;     // Device identity field of an address.
    localparam int          ADDR_QUAD_LSB = 3;     // Quadrant field of an address.
    localparam logic [1:0]  FIRST_QUAD    = 2'h0;
    localparam logic [1:0]  LAST_QUAD     = 2'h3;
    localparam logic [1:0]  QUAD_STEP     = 2'h1;
    localparam logic [7:0]  BUS_IDLE      = 8'hFF; // Level of an undriven flag bus.
    localparam logic [7:0]  ADDR_RESET    = 8'h00;
    localparam logic [4:0]  QUEUE_RESET   = 5'h00;
    localparam logic        LINE_IDLE     = 1'b1;  // Pulled-up level of the full flag line.
endpackage

// ---- rtl/flag_bus_if.sv ----
// Carrier between the flag logic of the queue device and its controller.
// Resolves the shared lines from their output enables; the token ring of a
// lone device is closed here, as the board would close it.
`timescale 1ns/1ps
interface flag_bus_if;
    // Almost-empty flag bus, read side.
    logic [7:0] almost_empty_flag_bus;
    logic [7:0] emptyBusOeN;
    logic [7:0] emptyBusLine;
    logic       empty_bus_sync_pulse;
    logic       empty_chain_token_in;
    logic       empty_chain_token_out;
    logic       almost_empty_bus_strobe;
    logic [7:0] read_address_bus;
    // Almost-full flag bus, write side.
    logic [7:0] almost_full_flag_bus;
    logic [7:0] fullBusOeN;
    logic [7:0] fullBusLine;
    logic       full_bus_sync_pulse;
    logic       fullChainTokenIn;
    logic       fullChainTokenOut;
    logic       almost_full_bus_strobe;
    logic [7:0] write_address_bus;
    logic       write_queue_select_enable;
    logic       writeEnable;
    // Full flag and configuration.
    logic       full_flag_out;
    logic       fullFlagOeN;
    logic       fullFlagLine;
    logic       flag_bus_mode_select;
    logic       serial_programming_done;

    // Undriven bits float to the pulled-up idle level.
    genvar b;
    for (b = 0; b < flag_bus_pkg::FLAG_W; b++) begin : g_res
        assign emptyBusLine[b] = emptyBusOeN[b] ? flag_bus_pkg::BUS_IDLE[b]
                                                : almost_empty_flag_bus[b];
        assign fullBusLine[b]  = fullBusOeN[b] ? flag_bus_pkg::BUS_IDLE[b]
                                               : almost_full_flag_bus[b];
    end
    assign fullFlagLine = fullFlagOeN ? flag_bus_pkg::LINE_IDLE : full_flag_out;

    // Lone device: a polled chain loops back on itself, a direct one is tied low.
    assign empty_chain_token_in = flag_bus_mode_select & empty_chain_token_out; // R6 R7
    assign fullChainTokenIn     = flag_bus_mode_select & fullChainTokenOut;

    modport device (
        output almost_empty_flag_bus, emptyBusOeN, empty_bus_sync_pulse,
        output empty_chain_token_out, almost_full_flag_bus, fullBusOeN,
        output full_bus_sync_pulse, fullChainTokenOut, full_flag_out, fullFlagOeN,
        output serial_programming_done,
        input  empty_chain_token_in, fullChainTokenIn, almost_empty_bus_strobe,
        input  read_address_bus, almost_full_bus_strobe, write_address_bus,
        input  write_queue_select_enable, writeEnable, flag_bus_mode_select
    );
    modport controller (
        output almost_empty_bus_strobe, read_address_bus, almost_full_bus_strobe,
        output write_address_bus, write_queue_select_enable, writeEnable,
        output flag_bus_mode_select,
        input  emptyBusLine, empty_bus_sync_pulse, fullBusLine, full_bus_sync_pulse,
        input  fullFlagLine, serial_programming_done
    );
endinterface

// ---- rtl/quad_sequencer.sv ----
// One flag bus: polled quadrant rotation with token passing, or direct
// quadrant selection by strobe. Used once for each flag bus of the device.
// Assumes mode and master straps are already held stable by the caller.
`timescale 1ns/1ps
module quad_sequencer (
    // Clock and reset.
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    // Configuration and control.
    input  wire logic        polled,
    input  wire logic        isMaster,
    input  wire logic        start,
    input  wire logic        tokenIn,
    input  wire logic        strobe,
    input  wire logic [1:0]  addrQuad,
    input  wire logic [31:0] flags,
    // Bus side, all registered.
    output logic      [7:0]  flagBus,
    output logic      [7:0]  flagBusOeN,
    output logic             sync,
    output logic             tokenOut
);
    logic       activeReg;
    logic       activeNext;
    logic [1:0] quadReg;
    logic [1:0] quadNext;

    // Next quadrant; a token arriving in polled mode always restarts at the first quadrant.
    always_comb begin
        activeNext = activeReg;
        quadNext   = quadReg;
        if (!polled) begin
            activeNext = 1'b1;
            if (strobe) begin
                quadNext = addrQuad; // R15 R18
            end
        end else if (tokenIn || (start && isMaster)) begin
            activeNext = 1'b1; // R3 R20
            quadNext   = flag_bus_pkg::FIRST_QUAD; // R5
        end else if (activeReg && quadReg == flag_bus_pkg::LAST_QUAD) begin
            activeNext = 1'b0; // Bus is handed on after the fourth quadrant.
            quadNext   = flag_bus_pkg::FIRST_QUAD;
        end else if (activeReg) begin
            quadNext = quadReg + flag_bus_pkg::QUAD_STEP; // R1 R19
        end
    end

    // Sequence state; in polled mode nobody drives the bus until a start pulse or token after reset, in direct mode it is driven at once.
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            activeReg <= 1'b0;
            quadReg   <= flag_bus_pkg::FIRST_QUAD; // R20
        end else begin
            activeReg <= activeNext;
            quadReg   <= quadNext;
        end
    end

    // Outputs follow the next state so that they match the quadrant shown.
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            flagBus    <= flag_bus_pkg::BUS_IDLE;
            flagBusOeN <= flag_bus_pkg::BUS_IDLE;
            sync       <= 1'b0;
            tokenOut   <= 1'b0;
        end else begin
            flagBus    <= flags[int'(quadNext) * flag_bus_pkg::FLAG_W +: flag_bus_pkg::FLAG_W];
            flagBusOeN <= {flag_bus_pkg::FLAG_W{!activeNext}};
            sync       <= polled && activeNext && quadNext == flag_bus_pkg::FIRST_QUAD; // R2
            tokenOut   <= polled && activeNext && quadNext == flag_bus_pkg::LAST_QUAD; // R4
        end
    end
endmodule // quad_sequencer

// ---- rtl/queue_flag_device.sv ----
// Flag reporting end of the multi-queue device: both flag buses, the chain
// tokens, the shared full flag line and the mode strap.
// Assumes one clock stands for read and write clocks, and that queue status
// vectors arrive from the queue core synchronous to it.
// The carrier closes the rings and pulls up the shared lines.
//
// How it works
// R1 - Polled empty bus rotates quadrants, wraps after four.
// R2 - Empty sync high only during quadrant one.
// R3 - Token on empty chain input grants the bus.
// R4 - Empty token output pulses with fourth quadrant.
// R5 - First quadrant loads on edge after token.
// R6 - Board ties token input low in direct mode.
// R7 - Polled chain loops last output to first.
// R8 - Full flag follows newly selected write queue.
// R9 - Controller writes only while full flag high.
// R10 - Only owning device drives shared full line.
// R11 - Full flag driven the cycle after selection.
// R12 - Full flag changes only on write clock.
// R13 - Mode strap at reset picks polled or direct.
// R14 - Mode strap held steady after reset.
// R15 - Direct full bus quadrant chosen by strobe.
// R16 - Full strobe held low in polled mode.
// R17 - No full strobe before programming done.
// R18 - Direct empty bus quadrant chosen by strobe.
// R19 - Polled full bus rotates, sync on quadrant one.
// R20 - Reset restarts sequence; master holds token first.
`timescale 1ns/1ps
module queue_flag_device (
    // Clock and reset.
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    // Link to the controller.
    flag_bus_if.device       link,
    // Status from the queue core.
    input  wire logic [31:0] almostEmptyFlags,
    input  wire logic [31:0] almostFullFlags,
    input  wire logic [31:0] queueFull,
    // Straps and programming state.
    input  wire logic [2:0]  deviceId,
    input  wire logic        masterStrap,
    input  wire logic        programmingDone,
    // Status towards the queue core.
    output logic             flagsPolled,
    output logic      [4:0]  writeQueue,
    output logic             writeQueueOwned
);
    logic       polledReg;
    logic       masterReg;
    logic [2:0] idReg;
    logic       startReg;
    logic       startedReg;

    logic [4:0] queueNext;
    logic       ownNext;
    logic       fullFlagReg;
    logic       fullFlagOeNReg;
    logic       doneReg;

    logic       afStrobe;
    logic       aeStrobe;

    // Straps are caught while reset is held and then frozen, so a strap that
    // wanders later cannot flip the bus mode under a running chain.
    // The mode pin is the controller's own register,
    // so it is settled long before reset ends.
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            polledReg <= link.flag_bus_mode_select; // R13
        end
    end

    // Master and identity straps, caught the same way.
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            masterReg <= masterStrap;
            idReg     <= deviceId;
        end
    end

    // One pulse after reset release starts the master's polled rotation.
    // Slaves ignore it and wait for a token.
    // A lone polled ring would never start without it.
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            startReg   <= 1'b0;
            startedReg <= 1'b0;
        end else begin
            startReg   <= !startedReg; // R20
            startedReg <= 1'b1;
        end
    end

    // Strobes count only in direct mode; polled sequencing ignores them.
    // This also guards against a strobe left high by the board.
    assign afStrobe = !polledReg && link.almost_full_bus_strobe;
    assign aeStrobe = !polledReg && link.almost_empty_bus_strobe;

    // Almost-empty flag bus, read side.
    // Polled: the token decides when this device owns the bus.
    // Direct: always driven, and the strobe picks the quadrant.
    quad_sequencer u_empty_seq (
        .clk_sys    (clk_sys),
        .rst_n      (rst_n),
        .polled     (polledReg),
        .isMaster   (masterReg),
        .start      (startReg),
        .tokenIn    (link.empty_chain_token_in), // R3
        .strobe     (aeStrobe), // R18
        .addrQuad   (link.read_address_bus[flag_bus_pkg::ADDR_QUAD_LSB +: flag_bus_pkg::QUAD_W]),
        .flags      (almostEmptyFlags),
        .flagBus    (link.almost_empty_flag_bus),
        .flagBusOeN (link.emptyBusOeN),
        .sync       (link.empty_bus_sync_pulse),
        .tokenOut   (link.empty_chain_token_out)
    );

    // Almost-full flag bus, write side.
    // Same engine, with its own ring and sync pulse.
    quad_sequencer u_full_seq (
        .clk_sys    (clk_sys),
        .rst_n      (rst_n),
        .polled     (polledReg),
        .isMaster   (masterReg),
        .start      (startReg),
        .tokenIn    (link.fullChainTokenIn),
        .strobe     (afStrobe), // R15
        .addrQuad   (link.write_address_bus[flag_bus_pkg::ADDR_QUAD_LSB +: flag_bus_pkg::QUAD_W]),
        .flags      (almostFullFlags),
        .flagBus    (link.almost_full_flag_bus),
        .flagBusOeN (link.fullBusOeN),
        .sync       (link.full_bus_sync_pulse), // R19
        .tokenOut   (link.fullChainTokenOut)
    );

    // Selected write queue: a new selection takes effect on its own edge, so
    // the flag below shows the new queue in the very next cycle.
    // Ownership compares the identity field with the caught strap.
    // The index is kept even when another device owns the queue.
    always_comb begin
        queueNext = writeQueue;
        ownNext   = writeQueueOwned;
        if (link.write_queue_select_enable) begin
            queueNext = link.write_address_bus[flag_bus_pkg::QUEUE_W-1:0];
            ownNext   = link.write_address_bus[flag_bus_pkg::ADDR_ID_LSB +: flag_bus_pkg::ID_W]
                        == idReg; // R10
        end
    end

    // Selected queue index, also reported to the queue core.
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            writeQueue <= flag_bus_pkg::QUEUE_RESET;
        end else begin
            writeQueue <= queueNext;
        end
    end

    // Ownership; reset leaves no queue owned, so every line starts released.
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            writeQueueOwned <= 1'b0;
        end else begin
            writeQueueOwned <= ownNext;
        end
    end

    // Full flag: high means room, updated only on the clock edge.
    // A non-owner's register still moves, but its pin stays released.
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            fullFlagReg <= flag_bus_pkg::LINE_IDLE;
        end else begin
            fullFlagReg <= !queueFull[queueNext]; // R8 R12
        end
    end

    // Drive enable: every device switches on the same edge, so owners never overlap.
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            fullFlagOeNReg <= 1'b1;
        end else begin
            fullFlagOeNReg <= !ownNext; // R10 R11
        end
    end
    assign link.full_flag_out = fullFlagReg;
    assign link.fullFlagOeN   = fullFlagOeNReg;

    // Programming-done output is active low: low once programming finished.
    // It stays high through reset, so strobes wait until it falls.
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            doneReg <= 1'b1;
        end else begin
            doneReg <= !programmingDone;
        end
    end
    assign link.serial_programming_done = doneReg;

    // Mode reported to the core; low through reset, then a copy of the caught strap.
    // It can change only in a reset and on the first edge after one.
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            flagsPolled <= 1'b0;
        end else begin
            flagsPolled <= polledReg;
        end
    end
endmodule // queue_flag_device

// ---- rtl/queue_flag_controller.sv ----
// Controller end: selects write queues, gates writes on the full flag, issues
// direct-mode strobes and tracks which quadrant each flag bus is showing in polled mode.
// Assumes the device end shares clk_sys and the carrier resolves the lines.
`timescale 1ns/1ps
module queue_flag_controller (
    // Clock and reset.
    input  wire logic       clk_sys,
    input  wire logic       rst_n,
    // Link to the device.
    flag_bus_if.controller  link,
    // Configuration.
    input  wire logic       modeCfg,
    // Requests from the user.
    input  wire logic       selectReq,
    input  wire logic [7:0] selectAddr,
    input  wire logic       writeReq,
    input  wire logic       afStrobeReq,
    input  wire logic       aeStrobeReq,
    input  wire logic [7:0] readAddr,
    // Answers to the user.
    output logic            writeAccepted,
    output logic            fullSeen,
    output logic      [1:0] afQuadShown,
    output logic      [7:0] afFlags,
    output logic      [1:0] aeQuadShown,
    output logic      [7:0] aeFlags
);
    logic modeReg;
    logic ready;

    // Mode strap set during reset and never moved afterwards.
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            modeReg <= modeCfg; // R14
        end
    end
    assign link.flag_bus_mode_select = modeReg;

    // Strobes wait for programming to end and never fire in polled mode.
    assign ready = !modeReg && !link.serial_programming_done; // R16 R17

    // Drive the device pins from registers.
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            link.write_address_bus         <= flag_bus_pkg::ADDR_RESET;
            link.read_address_bus          <= flag_bus_pkg::ADDR_RESET;
            link.write_queue_select_enable <= 1'b0;
            link.almost_full_bus_strobe    <= 1'b0;
            link.almost_empty_bus_strobe   <= 1'b0;
            link.writeEnable               <= 1'b0;
            writeAccepted                  <= 1'b0;
        end else begin
            link.write_address_bus         <= selectAddr;
            link.read_address_bus          <= readAddr;
            link.write_queue_select_enable <= selectReq;
            link.almost_full_bus_strobe    <= afStrobeReq && ready;
            link.almost_empty_bus_strobe   <= aeStrobeReq && ready;
            link.writeEnable               <= writeReq && link.fullFlagLine; // R9
            writeAccepted                  <= writeReq && link.fullFlagLine;
        end
    end

    // Quadrant tracking: sync marks quadrant one, later cycles count upward.
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            afQuadShown <= flag_bus_pkg::FIRST_QUAD;
            aeQuadShown <= flag_bus_pkg::FIRST_QUAD;
            afFlags     <= flag_bus_pkg::BUS_IDLE;
            aeFlags     <= flag_bus_pkg::BUS_IDLE;
            fullSeen    <= 1'b0;
        end else begin
            afQuadShown <= link.full_bus_sync_pulse ? flag_bus_pkg::FIRST_QUAD
                                                    : afQuadShown + flag_bus_pkg::QUAD_STEP;
            aeQuadShown <= link.empty_bus_sync_pulse ? flag_bus_pkg::FIRST_QUAD
                                                     : aeQuadShown + flag_bus_pkg::QUAD_STEP;
            afFlags     <= link.fullBusLine;
            aeFlags     <= link.emptyBusLine;
            fullSeen    <= !link.fullFlagLine;
        end
    end
endmodule // queue_flag_controller

// ---- bench/queue_flag_chk.sv ----
// Concurrent checks on the flag link between the device and controller ends.
// Assumes one clock and the carrier's signals wired in as plain inputs.
`timescale 1ns/1ps
module queue_flag_chk #(
    parameter logic [2:0] DEV_ID = 3'h2
) (
    // Clock and reset.
    input  wire logic       clk_sys,
    input  wire logic       rst_n,
    // Polled bus timing.
    input  wire logic       empty_bus_sync_pulse,
    input  wire logic       empty_chain_token_out,
    input  wire logic       empty_chain_token_in,
    input  wire logic       full_bus_sync_pulse,
    input  wire logic       fullChainTokenOut,
    // Full flag, selection and writes.
    input  wire logic       fullFlagOeN,
    input  wire logic       fullFlagLine,
    input  wire logic       write_queue_select_enable,
    input  wire logic [7:0] write_address_bus,
    input  wire logic       writeEnable,
    // Strobes and configuration.
    input  wire logic       almost_full_bus_strobe,
    input  wire logic       almost_empty_bus_strobe,
    input  wire logic       serial_programming_done,
    input  wire logic       flag_bus_mode_select
);
    logic [2:0] selIdReg;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    // Keeps the identity field of the last address, for the ownership check.
    always_ff @(posedge clk_sys) begin
        selIdReg <= write_address_bus[7:5];
    end

    // Each rotation is four quadrants long, token leaving with the last.
    a_empty_token_timing: assert property (empty_bus_sync_pulse |-> ##3 empty_chain_token_out)
        else $error("empty token not on fourth quadrant");
    a_empty_sync_once: assert property (empty_bus_sync_pulse |=> !empty_bus_sync_pulse [*3])
        else $error("empty sync high outside quadrant one");
    a_token_restarts_bus: assert property (empty_chain_token_in |=> empty_bus_sync_pulse)
        else $error("token did not load quadrant one");
    a_full_token_timing: assert property (full_bus_sync_pulse |-> ##3 fullChainTokenOut)
        else $error("full token not on fourth quadrant");
    // Only the owner of the selected queue takes the shared line.
    a_full_line_owner: assert property (write_queue_select_enable |=>
        fullFlagOeN == (selIdReg != DEV_ID))
        else $error("full flag drive does not follow ownership");
    a_full_drive_held: assert property (!write_queue_select_enable |=> $stable(fullFlagOeN))
        else $error("full flag drive changed without selection");
    a_strobe_gated: assert property ((almost_full_bus_strobe || almost_empty_bus_strobe) |->
        !serial_programming_done && !flag_bus_mode_select)
        else $error("strobe raised while polled or unprogrammed");
    a_write_when_free: assert property (writeEnable |-> $past(fullFlagLine))
        else $error("write issued against a full queue");
endmodule // queue_flag_chk

// ---- bench/test_queue_flag_status_bus.sv ----
// Self-checking bench: device and controller joined by the carrier.
// Assumes a lone polled device loops its tokens inside the carrier.
`timescale 1ns/1ps
module test_queue_flag_status_bus;
    localparam logic [2:0] DEV_ID = 3'h2;
    logic        clk_sys;
    logic        rst_n;
    logic [31:0] almostEmptyFlags;
    logic [31:0] almostFullFlags;
    logic [31:0] queueFull;
    logic        programmingDone;
    logic        modeCfg;
    logic        selectReq;
    logic [7:0]  selectAddr;
    logic        writeReq;
    logic        afStrobeReq;
    logic        aeStrobeReq;
    logic [7:0]  readAddr;
    logic        flagsPolled;
    logic        writeQueueOwned;
    logic        writeAccepted;
    logic [4:0]  writeQueue;
    logic        fullSeen;
    logic [1:0]  afQuadShown;
    logic [1:0]  aeQuadShown;
    logic [7:0]  afFlags;
    logic [7:0]  aeFlags;
    int          rot[$];
    logic        own;
    int          n_mismatch;
    int          n_checks;
    int          q;

    flag_bus_if link ();
    queue_flag_device queue_flag_device_inst (.clk_sys(clk_sys), .rst_n(rst_n), .link(link),
        .almostEmptyFlags(almostEmptyFlags), .almostFullFlags(almostFullFlags),
        .queueFull(queueFull), .deviceId(DEV_ID), .masterStrap(1'b1),
        .programmingDone(programmingDone), .flagsPolled(flagsPolled), .writeQueue(writeQueue),
        .writeQueueOwned(writeQueueOwned));
    queue_flag_controller queue_flag_controller_inst (.clk_sys(clk_sys), .rst_n(rst_n),
        .link(link), .modeCfg(modeCfg), .selectReq(selectReq), .selectAddr(selectAddr),
        .writeReq(writeReq), .afStrobeReq(afStrobeReq), .aeStrobeReq(aeStrobeReq),
        .readAddr(readAddr), .writeAccepted(writeAccepted), .fullSeen(fullSeen),
        .afQuadShown(afQuadShown), .afFlags(afFlags), .aeQuadShown(aeQuadShown),
        .aeFlags(aeFlags));
    queue_flag_chk #(.DEV_ID(DEV_ID)) queue_flag_chk_inst (.clk_sys(clk_sys), .rst_n(rst_n),
        .empty_bus_sync_pulse(link.empty_bus_sync_pulse),
        .empty_chain_token_out(link.empty_chain_token_out),
        .empty_chain_token_in(link.empty_chain_token_in),
        .full_bus_sync_pulse(link.full_bus_sync_pulse),
        .fullChainTokenOut(link.fullChainTokenOut), .fullFlagOeN(link.fullFlagOeN),
        .fullFlagLine(link.fullFlagLine), .writeEnable(link.writeEnable),
        .write_queue_select_enable(link.write_queue_select_enable),
        .write_address_bus(link.write_address_bus),
        .almost_full_bus_strobe(link.almost_full_bus_strobe),
        .almost_empty_bus_strobe(link.almost_empty_bus_strobe),
        .serial_programming_done(link.serial_programming_done),
        .flag_bus_mode_select(link.flag_bus_mode_select));

    // Free-running system clock, 100 ns period.
    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end

    // Compares one result against the model's value.
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Verdict and end of run.
    task automatic wrap_up();
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // Mode is only caught in reset, so each mode gets a reset of its own.
    task automatic do_reset(input logic mode);
        rst_n = 1'b0;
        modeCfg = mode;
        repeat (16) @(negedge clk_sys);
        rst_n = 1'b1;
    endtask

    // Main sequence: polled rotation and selections, then direct mode.
    initial begin
        {rst_n, modeCfg, selectReq, writeReq, afStrobeReq, aeStrobeReq} = 6'h00;
        {selectAddr, readAddr, n_mismatch, n_checks} = '0;
        programmingDone = 1'b1;
        void'($urandom(32'hb639_3ae0));
        almostEmptyFlags = $urandom();
        almostFullFlags = $urandom();
        queueFull = $urandom();
        do_reset(1'b1);
        repeat (2) @(posedge clk_sys);
        @(negedge clk_sys);
        chk(flagsPolled, 1'b1);
        rot = '{0, 1, 2, 3};
        for (int i = 0; i < 12; i++) begin
            q = rot.pop_front(); // The model rotates four quadrants and wraps.
            rot.push_back(q);
            chk(link.emptyBusLine, almostEmptyFlags[8*q +: 8]);
            chk(link.empty_bus_sync_pulse, q == 0);
            chk(link.empty_chain_token_out, q == 3);
            chk(link.fullBusLine, almostFullFlags[8*q +: 8]);
            chk(link.full_bus_sync_pulse, q == 0);
            if (i > 0) begin
                chk(aeQuadShown, (q + 3) % 4);
                chk(afQuadShown, (q + 3) % 4);
                chk(aeFlags, almostEmptyFlags[8*((q + 3) % 4) +: 8]);
                chk(afFlags, almostFullFlags[8*((q + 3) % 4) +: 8]);
            end
            aeStrobeReq = 1'($urandom());
            readAddr = 8'($urandom());
            @(negedge clk_sys);
        end
        aeStrobeReq = 1'b0;
        for (int i = 0; i < 10; i++) begin
            own = (i % 3) != 0;
            selectAddr = {own ? DEV_ID : 3'h5, 5'($urandom())};
            selectReq = 1'b1;
            @(negedge clk_sys);
            selectReq = 1'b0;
            @(negedge clk_sys);
            chk(link.fullFlagLine, own ? !queueFull[selectAddr[4:0]] : 1'b1);
            chk(writeQueueOwned, own);
            chk(writeQueue, selectAddr[4:0]);
            writeReq = 1'b1;
            @(negedge clk_sys);
            writeReq = 1'b0;
            chk(writeAccepted, own ? !queueFull[selectAddr[4:0]] : 1'b1);
            chk(fullSeen, own ? queueFull[selectAddr[4:0]] : 1'b0);
        end
        programmingDone = 1'b0;
        do_reset(1'b0);
        repeat (2) @(negedge clk_sys);
        chk(flagsPolled, 1'b0);
        chk(link.emptyBusLine, almostEmptyFlags[7:0]);
        {afStrobeReq, aeStrobeReq} = 2'h3;
        @(negedge clk_sys);
        chk({link.almost_full_bus_strobe, link.almost_empty_bus_strobe}, 2'h0);
        {afStrobeReq, aeStrobeReq} = 2'h0;
        programmingDone = 1'b1;
        repeat (3) @(negedge clk_sys);
        for (int i = 0; i < 8; i++) begin
            q = (i + 2) % 4;
            selectAddr = {3'($urandom()), 2'(q), 3'($urandom())};
            readAddr = {3'($urandom()), 2'(q + 1), 3'($urandom())};
            {afStrobeReq, aeStrobeReq} = 2'h3;
            @(negedge clk_sys);
            {afStrobeReq, aeStrobeReq} = 2'h0;
            @(negedge clk_sys);
            chk(link.fullBusLine, almostFullFlags[8*q +: 8]);
            chk(link.emptyBusLine, almostEmptyFlags[8*((q + 1) % 4) +: 8]);
            chk({link.empty_bus_sync_pulse, link.full_bus_sync_pulse}, 2'h0);
        end
        wrap_up();
    end

    // Cuts a hang short well past the expected run of about a hundred cycles.
    initial begin
        #(100 * 2000);
        n_mismatch++;
        wrap_up();
    end
endmodule // test_queue_flag_status_bus
